/* File: design/monitor_command_trigger_regs.sv */
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module mct_monitor_command_trigger_regs
    import mct_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic unlockOk,
    output mct_pulse_t goPulse,
    output mct_cfg_t cfgSampled,
    output logic voltCmpArmed,
    output logic tempCmpArmed,
    output logic [7:0] voltCmpSel,
    output logic [7:0] tempCmpSel,
    output logic linkManual,
    output logic tsrefOn,
    output logic vptatOn,
    output logic [5:0] pinOut,
    output logic [5:0] pinOutEn_n
);
    logic wrPend_q;
    logic [11:0] wrIdx_q;
    logic [7:0] trig_q;
    logic [7:0] otp_q;
    logic [7:0] pin_q;
    logic [5:0] pinDir_q;
    mct_cfg_t cfg_q;
    logic [7:0] wb;
    logic [7:0] rdByte;
    logic [7:0] rdStored;
    logic [7:0] rdMask;
    logic rdFwd;

    function automatic logic isWr(input logic [11:0] idx, input logic [11:0] w,
                                  input logic pend);
        return pend && (idx == w);
    endfunction

    function automatic logic busReq(input logic sel, input logic [1:0] trans);
        return sel && (trans == HTRANS_NONSEQ);
    endfunction

    // bits software may change in each register; the rest keep their stored value
    function automatic logic [7:0] wrMask(input logic [11:0] idx);
        case (idx)
            IDX_TRIGGER: return TRIG_RW_MASK;
            IDX_OTP_PROG: return OTP_RW_MASK;
            IDX_PIN_OUT, IDX_PIN_DIR: return PIN_MASK;
            IDX_BAL_CFG, IDX_CMP_CFG, IDX_AUX_CFG, IDX_CELL_CFG: return '1;
            default: return '0;
        endcase
    endfunction

    // transfer size not decoded: every register is one aligned word
    assign wb = hwdata[7:0];

    // always zero wait: one-cycle data phase
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wrPend_q <= 1'b0;
            wrIdx_q <= '0;
        end else if (hready) begin
            wrPend_q <= busReq(hsel, htrans) && hwrite;
            wrIdx_q <= haddr[13:2];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            trig_q <= RESET_BYTE;
        end else if (isWr(wrIdx_q, IDX_TRIGGER, wrPend_q)) begin
            trig_q <= wb & TRIG_RW_MASK; // go bits never stored
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            otp_q <= RESET_BYTE;
        end else if (isWr(wrIdx_q, IDX_OTP_PROG, wrPend_q)) begin
            otp_q <= wb & OTP_RW_MASK; // go bit never stored
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_q <= RESET_BYTE;
            pinDir_q <= '0;
        end else begin
            if (isWr(wrIdx_q, IDX_PIN_OUT, wrPend_q)) pin_q <= wb & PIN_MASK;
            if (isWr(wrIdx_q, IDX_PIN_DIR, wrPend_q)) pinDir_q <= wb[5:0];
        end
    end

    // live config; converters and balancing only see it through a go snapshot
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_q <= '0;
        end else begin
            if (isWr(wrIdx_q, IDX_BAL_CFG, wrPend_q)) cfg_q.balCfg <= wb;
            if (isWr(wrIdx_q, IDX_CMP_CFG, wrPend_q)) cfg_q.cmpCfg <= wb;
            if (isWr(wrIdx_q, IDX_AUX_CFG, wrPend_q)) cfg_q.auxCfg <= wb;
            if (isWr(wrIdx_q, IDX_CELL_CFG, wrPend_q)) cfg_q.cellCfg <= wb;
        end
    end

    // go pulses last one cycle, with config snapshotted the same edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            goPulse <= '0;
            // cmpCfg is never loaded: comparators keep their own latched selection
            cfgSampled <= '0;
        end else begin
            goPulse <= '0;
            if (isWr(wrIdx_q, IDX_TRIGGER, wrPend_q)) begin
                goPulse.cellGo <= wb[B_CELL_GO];
                goPulse.auxGo <= wb[B_AUX_GO];
                goPulse.balGo <= wb[B_BALANCE_TRIGGER];
                if (wb[B_CELL_GO]) cfgSampled.cellCfg <= cfg_q.cellCfg;
                if (wb[B_AUX_GO]) cfgSampled.auxCfg <= cfg_q.auxCfg;
                if (wb[B_BALANCE_TRIGGER]) cfgSampled.balCfg <= cfg_q.balCfg;
            end
            if (isWr(wrIdx_q, IDX_OTP_PROG, wrPend_q) && wb[B_PROGRAM_TRIGGER] && unlockOk) begin
                goPulse.progGo <= 1'b1;
                goPulse.progPage <= wb[B_PAGE_SEL];
            end
        end
    end

    // selection latched only on a 0->1 of the enable
    // armed flags trail the enable bit by one cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            voltCmpArmed <= 1'b0;
            tempCmpArmed <= 1'b0;
            voltCmpSel <= '0;
            tempCmpSel <= '0;
        end else begin
            voltCmpArmed <= trig_q[B_VCMP_EN];
            tempCmpArmed <= trig_q[B_TCMP_EN];
            if (trig_q[B_VCMP_EN] && !voltCmpArmed) voltCmpSel <= cfg_q.cmpCfg;
            if (trig_q[B_TCMP_EN] && !tempCmpArmed) tempCmpSel <= cfg_q.cmpCfg;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            linkManual <= 1'b0;
            tsrefOn <= 1'b0;
            vptatOn <= 1'b0;
            pinOut <= '0;
            pinOutEn_n <= '1;
        end else begin
            // receiver settle wait is the host's job; nothing here times it
            linkManual <= trig_q[B_DAISY_MAN];
            tsrefOn <= trig_q[B_TSREF_EN];
            vptatOn <= trig_q[B_VPTAT_EN];
            pinOut <= pin_q[5:0];
            pinOutEn_n <= ~pinDir_q;
        end
    end

    always_comb begin
        case (haddr[13:2])
            IDX_TRIGGER: rdStored = trig_q;
            IDX_OTP_PROG: rdStored = otp_q;
            IDX_PIN_OUT: rdStored = pin_q;
            IDX_BAL_CFG: rdStored = cfg_q.balCfg;
            IDX_CMP_CFG: rdStored = cfg_q.cmpCfg;
            IDX_AUX_CFG: rdStored = cfg_q.auxCfg;
            IDX_CELL_CFG: rdStored = cfg_q.cellCfg;
            IDX_PIN_DIR: rdStored = {2'h0, pinDir_q};
            IDX_STATUS: rdStored = {6'h00, tempCmpArmed, voltCmpArmed};
            default: rdStored = RESET_BYTE;
        endcase
    end

    // a read right behind a write to the same word would return the old value:
    // the write lands on the very edge that captures the read data
    assign rdMask = wrMask(haddr[13:2]);
    assign rdFwd = isWr(wrIdx_q, haddr[13:2], wrPend_q);
    assign rdByte = rdFwd ? ((wb & rdMask) | (rdStored & ~rdMask)) : rdStored;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hrdata <= WORD_ZERO;
        end else if (hready) begin
            hrdata <= WORD_ZERO;
            if (busReq(hsel, htrans) && !hwrite) hrdata <= {24'h000000, rdByte};
        end
    end

    // no wait states; back-to-back transfers rely on the read bypass above
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: include/mct_pkg.sv */
package mct_pkg;
    // register word indices as printed; byte address is four times the index
    localparam logic [11:0] IDX_TRIGGER = 12'h106;
    localparam logic [11:0] IDX_OTP_PROG = 12'h107;
    localparam logic [11:0] IDX_PIN_OUT = 12'h108;
    localparam logic [11:0] IDX_BAL_CFG = 12'h1f0;
    localparam logic [11:0] IDX_CMP_CFG = 12'h1f1;
    localparam logic [11:0] IDX_AUX_CFG = 12'h1f2;
    localparam logic [11:0] IDX_CELL_CFG = 12'h1f3;
    localparam logic [11:0] IDX_PIN_DIR = 12'h1f4;
    localparam logic [11:0] IDX_STATUS = 12'h1f5;

    // command_trigger_reg fields
    localparam int B_CELL_GO = 0;
    localparam int B_AUX_GO = 1;
    localparam int B_VCMP_EN = 2;
    localparam int B_TCMP_EN = 3;
    localparam int B_TSREF_EN = 4;
    localparam int B_BALANCE_TRIGGER = 5;
    localparam int B_DAISY_MAN = 6;
    localparam int B_VPTAT_EN = 7;
    // otp_program_control fields
    localparam int B_PROGRAM_TRIGGER = 0;
    localparam int B_PAGE_SEL = 1;

    localparam logic [7:0] TRIG_RW_MASK = 8'hdc;
    localparam logic [7:0] OTP_RW_MASK = 8'h02;
    localparam logic [7:0] PIN_MASK = 8'h3f;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // host must wait this long after enabling the upper link receiver
    localparam int LINK_WAIT_US = 100;
    localparam int CLK_MHZ = 100;
    localparam int LINK_WAIT_CYC = LINK_WAIT_US * CLK_MHZ;

    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    typedef struct packed {
        logic cellGo;
        logic auxGo;
        logic balGo;
        logic progGo;
        logic progPage;
    } mct_pulse_t;

    typedef struct packed {
        logic [7:0] balCfg;
        logic [7:0] cmpCfg;
        logic [7:0] auxCfg;
        logic [7:0] cellCfg;
    } mct_cfg_t;
endpackage

/* File: sim/mct_monitor_command_trigger_regs_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module mct_monitor_command_trigger_regs_tb
    import mct_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, unlockOk = 1'b0;
    logic hreadyout, hresp, lm, tr, vp, va, ta;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
    logic [7:0] d, c, vs, ts;
    logic [5:0] po, pe;
    mct_pulse_t gp;
    mct_cfg_t cs;
    logic [11:0] ra [4] = '{IDX_TRIGGER, IDX_OTP_PROG, IDX_PIN_OUT, 12'h1ff};
    logic [11:0] ci [3] = '{IDX_BAL_CFG, IDX_AUX_CFG, IDX_CELL_CFG};
    logic [31:0] gb [3] = '{32'h20, 32'h2, 32'h1};
    integer fails = 0, checks_done = 0, cyc = 0, seed = 32'h0d2c, i;
    integer progCnt = 0, pn;
    logic progPg = 1'b0;
    mct_monitor_command_trigger_regs mct_monitor_command_trigger_regs_inst (
        .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .unlockOk(unlockOk),
        .goPulse(gp), .cfgSampled(cs), .voltCmpArmed(va), .tempCmpArmed(ta),
        .voltCmpSel(vs), .tempCmpSel(ts), .linkManual(lm), .tsrefOn(tr), .vptatOn(vp),
        .pinOut(po), .pinOutEn_n(pe));
    always #5 clk = ~clk;
    // program pulses last one cycle, so they are counted as they pass
    always @(posedge clk) begin
        if (gp.progGo === 1'b1) begin
            progCnt <= progCnt + 1;
            progPg <= gp.progPage;
        end
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails = fails + 1;
            results();
        end
    end
    task results();
        if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] a, input logic [31:0] e);
        checks_done = checks_done + 1;
        if (a !== e) begin
            fails = fails + 1;
            $display("FAIL %0t got %h exp %h", $time, a, e);
        end
    endtask
    function logic [31:0] fld(input mct_cfg_t s, input int k);
        return k == 0 ? s.balCfg : k == 1 ? s.auxCfg : s.cellCfg;
    endfunction
    // returns three edges after the data phase so armed flags and snapshots have landed
    task xfer(input logic [11:0] idx, input logic w, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {18'h0, idx, 2'b00};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
        hsel <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    // write then read of one word, back to back
    task wr_rd(input logic [11:0] idx, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {18'h0, idx, 2'b00};
        htrans <= HTRANS_NONSEQ;
        hwrite <= 1'b1;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hwrite <= 1'b0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
        hsel <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 4; i++) begin
            xfer(ra[i], 1'b0, 32'h0);
            chk(r, 32'h0);
        end
        for (i = 0; i < 3; i++) begin
            d = $random(seed);
            xfer(ci[i], 1'b1, {24'h0, d});
            xfer(IDX_TRIGGER, 1'b1, gb[i]);
            xfer(ci[i], 1'b1, {24'h0, ~d});
            chk(fld(cs, i), {24'h0, d});
        end
        d = $random(seed);
        xfer(IDX_CMP_CFG, 1'b1, {24'h0, d});
        xfer(IDX_TRIGGER, 1'b1, 32'hc);
        xfer(IDX_CMP_CFG, 1'b1, {24'h0, ~d});
        chk({vs, ts, va, ta, cs.cmpCfg}, {d, d, 2'b11, 8'h00});
        xfer(IDX_TRIGGER, 1'b1, 32'h0);
        xfer(IDX_TRIGGER, 1'b1, 32'hc);
        chk({vs, ts}, {~d, ~d});
        for (i = 0; i < 12; i++) begin
            d = $random(seed);
            c = $random(seed);
            @(posedge clk) unlockOk <= c[7];
            xfer(IDX_TRIGGER, 1'b1, {c, d, c, d}); // no link traffic follows
            xfer(IDX_TRIGGER, 1'b0, 32'h0);
            chk(r, {24'h0, d & TRIG_RW_MASK});
            chk({lm, tr, vp}, {d[6], d[4], d[7]});
            pn = progCnt;
            xfer(IDX_OTP_PROG, 1'b1, {24'h0, d});
            chk(progCnt - pn, {31'h0, d[B_PROGRAM_TRIGGER] & c[7]});
            if (d[B_PROGRAM_TRIGGER] && c[7]) chk({31'h0, progPg}, {31'h0, d[B_PAGE_SEL]});
            xfer(IDX_OTP_PROG, 1'b0, 32'h0);
            chk(r, {24'h0, d & OTP_RW_MASK});
            wr_rd(IDX_PIN_OUT, {d, c, d, c});
            chk(r, {24'h0, c & PIN_MASK});
            xfer(IDX_PIN_DIR, 1'b1, {24'h0, c});
            xfer(IDX_PIN_OUT, 1'b1, {c, d, c, d});
            xfer(IDX_PIN_OUT, 1'b0, 32'h0);
            chk(r, {24'h0, d & PIN_MASK});
            chk({po, pe, hresp}, {d[5:0], ~c[5:0], 1'b0});
        end
        results();
    end
endmodule
`default_nettype wire

/* File: sim/mct_regs_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module mct_regs_sva
    import mct_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hreadyout,
    input wire logic unlockOk,
    input wire mct_pulse_t goPulse,
    input wire logic voltCmpArmed,
    input wire logic linkManual,
    input wire logic [5:0] pinOut
);
    wire logic wr = hsel && htrans == HTRANS_NONSEQ && hwrite;
    logic wt, wp, wo;
    // high during the data phase of a write to the register
    always_ff @(posedge clk) begin
        wt <= rst_n && wr && haddr == {18'h0, IDX_TRIGGER, 2'b00};
        wp <= rst_n && wr && haddr == {18'h0, IDX_PIN_OUT, 2'b00};
        wo <= rst_n && wr && haddr == {18'h0, IDX_OTP_PROG, 2'b00};
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_rdy; hreadyout; endproperty
    a_rdy: assert property (p_rdy) else $error("not ready");
    property p_cell; wt && hwdata[0] |=> goPulse.cellGo; endproperty
    a_cell: assert property (p_cell) else $error("no cell go");
    property p_aux; wt && hwdata[1] |=> goPulse.auxGo; endproperty
    a_aux: assert property (p_aux) else $error("no aux go");
    property p_bal; wt && hwdata[5] |=> goPulse.balGo ##1 !goPulse.balGo; endproperty
    a_bal: assert property (p_bal) else $error("bad balance_trigger");
    property p_volt; wt && hwdata[2] |=> ##[0:1] voltCmpArmed; endproperty
    a_volt: assert property (p_volt) else $error("not armed");
    property p_man; wt |=> ##1 linkManual == $past(hwdata[6], 2); endproperty
    a_man: assert property (p_man) else $error("bad link mode");
    property p_prog; goPulse.progGo |-> $past(unlockOk); endproperty
    a_prog: assert property (p_prog) else $error("prog while locked");
    property p_program_trigger;
        wo && hwdata[B_PROGRAM_TRIGGER] && unlockOk |=>
            goPulse.progGo && goPulse.progPage == $past(hwdata[B_PAGE_SEL]);
    endproperty
    a_program_trigger: assert property (p_program_trigger) else $error("no program_trigger");
    property p_pin; wp |=> ##1 pinOut == $past(hwdata[5:0], 2); endproperty
    a_pin: assert property (p_pin) else $error("bad pin level");
    c_bal: cover property (goPulse.balGo);
    c_prog: cover property (goPulse.progGo);
    c_volt: cover property (voltCmpArmed);
endmodule
bind mct_monitor_command_trigger_regs mct_regs_sva mct_regs_sva_i (.clk(clk), .rst_n(rst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hreadyout(hreadyout), .unlockOk(unlockOk), .goPulse(goPulse),
    .voltCmpArmed(voltCmpArmed), .linkManual(linkManual), .pinOut(pinOut));
`default_nettype wire
